/* File: sps_pkg.sv */
/*
 * constants, state encoding and shared functions of the strobe position block.
 * assumes a single 40 mhz pclk domain and an apb slave with 32-bit data.
 */
package sps_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_RANGE = 10'h041;
    localparam logic [9:0] IDX_CFG = 10'h042;
    localparam logic [9:0] IDX_CTRL = 10'h0d2;
    localparam logic [9:0] IDX_EQLIM = 10'h0d5;
    localparam logic [9:0] IDX_CLK_STAT = 10'h0d6;
    localparam logic [9:0] IDX_DATA_STAT = 10'h0d7;
    localparam logic [9:0] IDX_STROBE = 10'h020;

    // values after reset
    localparam logic [7:0] RANGE_SMALL_RST = 8'h7a;
    localparam logic [7:0] RANGE_LARGE_RST = 8'h0e;
    localparam logic [7:0] CFG_RST = 8'h70;
    localparam logic [7:0] CTRL_RST = 8'h04;
    localparam logic [7:0] EQLIM_RST = 8'h2f;
    localparam logic [7:0] STROBE_RST = 8'h00;

    // field positions
    localparam int CFG_MANUAL_BIT = 0;
    localparam int CFG_INNER_BIT = 1;
    localparam int CFG_PAR_BIT = 4;
    localparam int CFG_ENC_BIT = 5;
    localparam int CFG_CLKERR_BIT = 6;
    localparam int CTRL_EQMIN_BIT = 2;
    localparam int CTRL_RESTART_BIT = 3;
    localparam int STB_BASE_HI_BIT = 7;
    localparam int STB_BASE_LO_BIT = 3;

    // strobe geometry
    localparam logic [3:0] NOMINAL_POS = 4'h7;
    localparam logic [3:0] LAST_POS = 4'he;
    localparam logic [3:0] BASE_BUFFERS = 4'h6;

    // dwell per candidate setting
    localparam int CLK_MHZ = 40;
    localparam int DWELL_US = 100;
    localparam logic [11:0] DWELL_CYCLES = 12'(DWELL_US * CLK_MHZ);
    // cycles at the start of a dwell whose link state still belongs to the previous candidate
    localparam logic [11:0] GUARD_CYCLES = 12'h010;

    typedef enum logic [1:0] {
        SPS_START = 2'b00,
        SPS_SETTLE = 2'b01,
        SPS_EVAL = 2'b10,
        SPS_HOLD = 2'b11
    } sps_state_e;

    // buffers in a delay line: setting plus base, base only once the line is in use
    function automatic logic [3:0] sps_taps(input logic [2:0] dly, input logic base_zero);
        sps_taps = (dly == 3'h0 || base_zero) ? {1'b0, dly} : {1'b0, dly} + BASE_BUFFERS;
    endfunction
endpackage

/* File: sps_pos_map.sv */
/*
 * translation of a strobe position, or of a manual strobe setting, into
 * clock and data delay settings and delay line buffer counts.
 * purely combinational; the caller registers the results.
 */
module sps_pos_map (
    input wire logic manual,
    input wire logic [3:0] pos,
    input wire logic [7:0] strobe,
    output logic [2:0] clk_dly,
    output logic [2:0] data_dly,
    output logic [3:0] clk_taps,
    output logic [3:0] data_taps
);
    import sps_pkg::*;

    logic base_zero;

    assign base_zero = strobe[STB_BASE_HI_BIT] & strobe[STB_BASE_LO_BIT];

    always_comb begin
        clk_dly = 3'h0;
        data_dly = 3'h0;
        if (manual) begin
            clk_dly = strobe[2:0];
            data_dly = strobe[6:4];
        end else if (pos < NOMINAL_POS) begin
            clk_dly = 3'(NOMINAL_POS - pos);
        end else if (pos <= LAST_POS) begin
            data_dly = 3'(pos - NOMINAL_POS);
        end
    end

    // extra base buffers push every off-nominal position further out unless strobe bits 7 and 3 are both set
    assign clk_taps = sps_taps(clk_dly, base_zero);
    assign data_taps = sps_taps(data_dly, base_zero);
endmodule

/* File: sps_top.sv */
/*
 * strobe position adaptation: apb register file, adaptive search of strobe
 * position and equalizer level, manual override and applied delay status.
 * assumes link_locked and the error strobes come from pclk-domain logic.
 */
// Behaviour
// - fifteen strobe positions: seven late, seven early, one nominal.
// - late sampling delays the clock by setting 0 to 7.
// - early sampling delays the data by setting 0 to 7.
// - positions 0-6 clock 7..1, 7 none, 8-14 data 1..7.
// - base delay six buffers, zero when strobe bits 7 and 3 set.
// - six-buffer base widens spacing around nominal position 7.
// - applied clock delay readable in bits 2:0 at 0xd6.
// - applied data delay readable in bits 2:0 at 0xd7.
// - adaptive and manual modes; adaptive after reset.
// - manual mode holds written position until software writes again.
// - default order sweeps all equalizer levels before next strobe position.
// - search starts at minimum, increments to maximum, stops on pass.
// - default limits 7..10 small variant, 0..14 large variant.
// - pass needs lock and zero enabled errors; parity, encoder, clock on.
// - manual writes data delay 6:4, clock delay 2:0, applied.
// - writing restart bit 3 at 0xd2 restarts the search.
module sps_top #(
    parameter bit LARGE_VARIANT = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    input wire logic link_locked,
    input wire logic parity_err,
    input wire logic encoder_err,
    input wire logic clock_err,
    output logic [2:0] clk_delay_q,
    output logic [2:0] data_delay_q,
    output logic [3:0] clk_taps_q,
    output logic [3:0] data_taps_q,
    output logic [3:0] eq_level_q,
    output logic search_done_q
);
    import sps_pkg::*;

    localparam logic [7:0] RANGE_RST = LARGE_VARIANT ? RANGE_LARGE_RST : RANGE_SMALL_RST;

    logic [7:0] range_q;
    logic [7:0] cfg_q;
    logic [7:0] ctrl_q;
    logic [7:0] eqlim_q;
    logic [7:0] strobe_q;
    logic restart_q;
    sps_state_e st_q;
    logic [3:0] pos_q;
    logic [3:0] eq_q;
    logic [11:0] dwell_q;
    logic fail_q;
    logic setup;
    logic access;
    logic wr;
    logic [9:0] widx;
    logic [7:0] rd_data;
    logic rd_hit;
    logic manual;
    logic inner;
    logic [3:0] pos_lo;
    logic [3:0] pos_hi;
    logic [3:0] eq_lo;
    logic [3:0] eq_hi;
    logic err_now;
    logic [3:0] next_pos;
    logic [3:0] next_eq;
    logic [2:0] map_clk;
    logic [2:0] map_data;
    logic [3:0] map_clk_taps;
    logic [3:0] map_data_taps;

    assign setup = psel & ~penable;
    assign access = psel & penable & pready_q;
    assign wr = access & pwrite;
    assign widx = paddr[11:2];

    assign manual = cfg_q[CFG_MANUAL_BIT];
    assign inner = cfg_q[CFG_INNER_BIT];
    assign pos_lo = range_q[7:4];
    assign pos_hi = range_q[3:0];
    assign eq_lo = ctrl_q[CTRL_EQMIN_BIT] ? eqlim_q[7:4] : 4'h0;
    assign eq_hi = eqlim_q[3:0];

    assign err_now = ~link_locked | (cfg_q[CFG_PAR_BIT] & parity_err)
                   | (cfg_q[CFG_ENC_BIT] & encoder_err) | (cfg_q[CFG_CLKERR_BIT] & clock_err);

    always_comb begin
        rd_hit = 1'b1;
        unique case (widx)
            IDX_RANGE: rd_data = range_q;
            IDX_CFG: rd_data = cfg_q;
            IDX_CTRL: rd_data = ctrl_q;
            IDX_EQLIM: rd_data = eqlim_q;
            IDX_CLK_STAT: rd_data = {5'h00, clk_delay_q};
            IDX_DATA_STAT: rd_data = {5'h00, data_delay_q};
            IDX_STROBE: rd_data = strobe_q;
            default: begin
                rd_data = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // data is captured in the setup cycle so pready can rise with penable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~rd_hit;
            if (setup) begin
                prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_data};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_q <= RANGE_RST;
            cfg_q <= CFG_RST;
            ctrl_q <= CTRL_RST;
            eqlim_q <= EQLIM_RST;
            strobe_q <= STROBE_RST;
        end else if (wr) begin
            unique case (widx)
                IDX_RANGE: range_q <= pwdata[7:0];
                IDX_CFG: cfg_q <= pwdata[7:0];
                IDX_CTRL: ctrl_q <= {5'h00, pwdata[CTRL_EQMIN_BIT], 2'h0};
                IDX_EQLIM: eqlim_q <= pwdata[7:0];
                IDX_STROBE: strobe_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // restart bit reads back as zero; it only makes a one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= wr && widx == IDX_CTRL && pwdata[CTRL_RESTART_BIT];
        end
    end

    always_comb begin
        next_pos = pos_q;
        next_eq = eq_q;
        if (inner) begin
            if (pos_q >= pos_hi) begin
                next_pos = pos_lo;
                next_eq = (eq_q >= eq_hi) ? eq_lo : eq_q + 4'h1;
            end else begin
                next_pos = pos_q + 4'h1;
            end
        end else begin
            if (eq_q >= eq_hi) begin
                next_eq = eq_lo;
                next_pos = (pos_q >= pos_hi) ? pos_lo : pos_q + 4'h1;
            end else begin
                next_eq = eq_q + 4'h1;
            end
        end
    end

    // manual mode parks the search in start so leaving it restarts cleanly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= SPS_START;
            pos_q <= 4'h0;
            eq_q <= 4'h0;
            dwell_q <= 12'h000;
            fail_q <= 1'b0;
            search_done_q <= 1'b0;
        end else if (manual || restart_q) begin
            st_q <= SPS_START;
            search_done_q <= 1'b0;
        end else begin
            unique case (st_q)
                SPS_START: begin
                    pos_q <= pos_lo;
                    eq_q <= eq_lo;
                    dwell_q <= DWELL_CYCLES;
                    fail_q <= 1'b0;
                    st_q <= SPS_SETTLE;
                end
                SPS_SETTLE: begin
                    // delays and far-end lock lag the step by a few edges; judging them would fail every candidate
                    if (dwell_q < DWELL_CYCLES - GUARD_CYCLES) begin
                        fail_q <= fail_q | err_now;
                    end
                    if (dwell_q <= 12'h001) begin
                        st_q <= SPS_EVAL;
                    end else begin
                        dwell_q <= dwell_q - 12'h001;
                    end
                end
                SPS_EVAL: begin
                    if (!fail_q) begin
                        st_q <= SPS_HOLD;
                        search_done_q <= 1'b1;
                    end else begin
                        pos_q <= next_pos;
                        eq_q <= next_eq;
                        dwell_q <= DWELL_CYCLES;
                        fail_q <= 1'b0;
                        st_q <= SPS_SETTLE;
                    end
                end
                SPS_HOLD: begin
                    // a lost lock means the chosen setting no longer holds
                    if (!link_locked) begin
                        st_q <= SPS_START;
                        search_done_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    sps_pos_map u_map (
        .manual(manual),
        .pos(pos_q),
        .strobe(strobe_q),
        .clk_dly(map_clk),
        .data_dly(map_data),
        .clk_taps(map_clk_taps),
        .data_taps(map_data_taps)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_delay_q <= 3'h0;
            data_delay_q <= 3'h0;
            clk_taps_q <= 4'h0;
            data_taps_q <= 4'h0;
            eq_level_q <= 4'h0;
        end else begin
            clk_delay_q <= map_clk;
            data_delay_q <= map_data;
            clk_taps_q <= map_clk_taps;
            data_taps_q <= map_data_taps;
            eq_level_q <= eq_q;
        end
    end

    logic wr_strobe;
    assign wr_strobe = wr && widx == IDX_STROBE;

    a_map_late: assert property (@(posedge pclk) disable iff (!presetn)
        !manual && pos_q < NOMINAL_POS |=> clk_delay_q == 3'(NOMINAL_POS - $past(pos_q)) && data_delay_q == 3'h0)
        else $error("late position mapped wrongly");

    a_map_early: assert property (@(posedge pclk) disable iff (!presetn)
        !manual && pos_q > NOMINAL_POS && pos_q <= LAST_POS
        |=> data_delay_q == 3'($past(pos_q) - NOMINAL_POS) && clk_delay_q == 3'h0)
        else $error("early position mapped wrongly");

    a_base_widen: assert property (@(posedge pclk) disable iff (!presetn)
        !(strobe_q[STB_BASE_HI_BIT] & strobe_q[STB_BASE_LO_BIT]) && map_clk != 3'h0
        |=> clk_taps_q == {1'b0, clk_delay_q} + 4'h6)
        else $error("six buffer base not added");

    a_status_clk: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && widx == IDX_CLK_STAT |-> prdata_q == {29'h0, $past(clk_delay_q)})
        else $error("clock delay status mismatch");

    a_status_data: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pwrite && widx == IDX_DATA_STAT |-> prdata_q == {29'h0, $past(data_delay_q)})
        else $error("data delay status mismatch");

    a_manual_hold: assert property (@(posedge pclk) disable iff (!presetn)
        manual && $past(manual) && $stable(strobe_q) |=> $stable(clk_delay_q) && $stable(data_delay_q))
        else $error("manual delay changed without write");

    a_manual_apply: assert property (@(posedge pclk) disable iff (!presetn)
        wr_strobe && cfg_q[CFG_MANUAL_BIT] |=> ##1 clk_delay_q == $past(pwdata[2:0], 2))
        else $error("manual clock delay not applied");

    a_outer_step: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == SPS_EVAL && fail_q && !inner && eq_q < eq_hi && !manual && !restart_q
        |=> pos_q == $past(pos_q) && eq_q == $past(eq_q) + 4'h1)
        else $error("outer loop did not step equalizer");

    a_search_start: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == SPS_START && !manual && !restart_q |=> pos_q == $past(pos_lo) && st_q == SPS_SETTLE)
        else $error("search did not start at minimum");

    a_hold_stable: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == SPS_HOLD && $past(st_q) == SPS_HOLD |-> $stable(pos_q) && $stable(eq_q))
        else $error("position moved after pass");

    a_pass_clean: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == SPS_HOLD && $past(st_q) == SPS_EVAL |-> !$past(fail_q))
        else $error("failing setting accepted");

    a_wrap_search: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == SPS_EVAL && fail_q && !inner && eq_q >= eq_hi && pos_q >= pos_hi && !manual && !restart_q
        |=> pos_q == $past(pos_lo) && eq_q == $past(eq_lo))
        else $error("exhausted search did not wrap");

    a_restart_go: assert property (@(posedge pclk) disable iff (!presetn)
        restart_q |=> st_q == SPS_START ##1 (manual || st_q == SPS_SETTLE))
        else $error("restart ignored");

    a_base_zero: assert property (@(posedge pclk) disable iff (!presetn)
        strobe_q[STB_BASE_HI_BIT] && strobe_q[STB_BASE_LO_BIT]
        |=> clk_taps_q == {1'b0, clk_delay_q} && data_taps_q == {1'b0, data_delay_q})
        else $error("zero buffer base not applied");

    a_manual_data: assert property (@(posedge pclk) disable iff (!presetn)
        wr_strobe && manual |=> ##1 data_delay_q == $past(pwdata[6:4], 2))
        else $error("manual data delay not applied");

    a_settle_guard: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == SPS_SETTLE && dwell_q < DWELL_CYCLES - GUARD_CYCLES && err_now && !manual && !restart_q
        |=> fail_q)
        else $error("error during dwell not recorded");

    a_lock_drop: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == SPS_HOLD && !link_locked && !manual && !restart_q |=> st_q == SPS_START && !search_done_q)
        else $error("lost lock did not restart search");

    a_inner_step: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == SPS_EVAL && fail_q && inner && pos_q < pos_hi && !manual && !restart_q
        |=> pos_q == $past(pos_q) + 4'h1 && eq_q == $past(eq_q))
        else $error("inner loop did not step strobe position");

    c_pass: cover property (@(posedge pclk) disable iff (!presetn) st_q == SPS_EVAL ##1 st_q == SPS_HOLD);
    c_wrap: cover property (@(posedge pclk) disable iff (!presetn)
        st_q == SPS_EVAL && fail_q && pos_q >= pos_hi && eq_q >= eq_hi);
    c_manual: cover property (@(posedge pclk) disable iff (!presetn) wr_strobe && manual);
    c_inner: cover property (@(posedge pclk) disable iff (!presetn) st_q == SPS_EVAL && fail_q && inner);
endmodule

/* File: sps_serializer_model.sv */
/*
 * behavioural far end of the serial link: locks only at one strobe setting
 * and one equalizer level chosen by the bench, and can corrupt parity there.
 * assumes it is clocked by pclk and fed the block's applied delays.
 */
module sps_serializer_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] clk_delay,
    input wire logic [2:0] data_delay,
    input wire logic [3:0] eq_level,
    input wire logic [2:0] good_clk,
    input wire logic [2:0] good_data,
    input wire logic [3:0] good_eq,
    input wire logic parity_bad,
    output logic link_locked,
    output logic parity_err,
    output logic encoder_err,
    output logic clock_err
);
    logic hit;
    assign hit = (clk_delay == good_clk) && (data_delay == good_data) && (eq_level == good_eq);
    // a misaligned eye shows as lost lock plus framing noise, as on a real cable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_locked <= 1'b0;
            parity_err <= 1'b0;
            encoder_err <= 1'b0;
            clock_err <= 1'b0;
        end else begin
            link_locked <= hit;
            parity_err <= hit & parity_bad & ~parity_err;
            encoder_err <= ~hit;
            clock_err <= ~hit;
        end
    end
endmodule

/* File: sps_top_test.sv */
/*
 * self-checking bench of the strobe position block: apb master tasks,
 * manual table sweep, adaptive search order, wrap and error filtering.
 * assumes the serializer model in its own file and the small variant.
 */
module sps_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sps_pkg::*;
    localparam logic [11:0] A_RANGE = {IDX_RANGE, 2'b00};
    localparam logic [11:0] A_CFG = {IDX_CFG, 2'b00};
    localparam logic [11:0] A_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [11:0] A_EQLIM = {IDX_EQLIM, 2'b00};
    localparam logic [11:0] A_CST = {IDX_CLK_STAT, 2'b00};
    localparam logic [11:0] A_DST = {IDX_DATA_STAT, 2'b00};
    localparam logic [11:0] A_STB = {IDX_STROBE, 2'b00};
    logic pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q, search_done_q, er, parity_bad;
    logic link_locked, parity_err, encoder_err, clock_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_q, rd;
    logic [2:0] clk_delay_q, data_delay_q, good_clk, good_data;
    logic [3:0] clk_taps_q, data_taps_q, eq_level_q, good_eq;
    logic [5:0] v;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    sps_top #(.LARGE_VARIANT(1'b0)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
        .pslverr_q(pslverr_q), .link_locked(link_locked), .parity_err(parity_err),
        .encoder_err(encoder_err), .clock_err(clock_err), .clk_delay_q(clk_delay_q),
        .data_delay_q(data_delay_q), .clk_taps_q(clk_taps_q), .data_taps_q(data_taps_q),
        .eq_level_q(eq_level_q), .search_done_q(search_done_q));
    sps_serializer_model far (.pclk(pclk), .presetn(presetn), .clk_delay(clk_delay_q),
        .data_delay(data_delay_q), .eq_level(eq_level_q), .good_clk(good_clk), .good_data(good_data),
        .good_eq(good_eq), .parity_bad(parity_bad), .link_locked(link_locked), .parity_err(parity_err),
        .encoder_err(encoder_err), .clock_err(clock_err));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 80000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready_q ends this wait; the bench timeout ends it if pready_q never rises
        do begin
            @(posedge pclk);
        end while (pready_q !== 1'b1);
        rd = prdata_q;
        er = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [5:0] dly_of(input logic [3:0] pos);
        if (pos < 4'h7) return {3'(4'h7 - pos), 3'h0};
        return {3'h0, 3'(pos - 4'h7)};
    endfunction

    function automatic logic [3:0] taps6(input logic [2:0] d);
        return (d == 3'h0) ? 4'h0 : {1'b0, d} + 4'h6;
    endfunction

    task automatic wait_cand(input logic [3:0] pos, input logic [3:0] eq, input int lim);
        int n;
        logic [9:0] e;
        n = 0;
        e = {dly_of(pos), eq};
        while ({clk_delay_q, data_delay_q, eq_level_q} !== e && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk({22'h0, clk_delay_q, data_delay_q, eq_level_q}, {22'h0, e});
    endtask

    task automatic wait_done(input int lim);
        int n;
        n = 0;
        while (search_done_q !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, search_done_q}, 32'h1);
    endtask

    task automatic set_far(input logic [2:0] c, input logic [2:0] d, input logic [3:0] q, input logic p);
        good_clk <= c;
        good_data <= d;
        good_eq <= q;
        parity_bad <= p;
    endtask

    task automatic test_reset();
        apb(1'b0, A_RANGE, 32'h0);
        chk(rd, {24'h0, RANGE_SMALL_RST});
        apb(1'b0, A_CFG, 32'h0);
        chk(rd, {24'h0, CFG_RST});
        apb(1'b0, A_STB, 32'h0);
        chk(rd, {24'h0, STROBE_RST});
        apb(1'b0, 12'hffc, 32'h0);
        chk({31'h0, er}, 32'h1);
        wait_cand(4'h7, 4'h2, 10);
        $display("test_reset done");
    endtask

    task automatic test_manual();
        apb(1'b1, A_CFG, 32'h71);
        for (int p = 0; p < 15; p++) begin
            v = dly_of(4'(p));
            apb(1'b1, A_STB, {25'h0, v[2:0], 1'b0, v[5:3]});
            repeat (3) @(posedge pclk);
            chk({29'h0, clk_delay_q}, {29'h0, v[5:3]});
            chk({29'h0, data_delay_q}, {29'h0, v[2:0]});
            chk({24'h0, clk_taps_q, data_taps_q}, {24'h0, taps6(v[5:3]), taps6(v[2:0])});
            repeat (40) @(posedge pclk);
            apb(1'b0, A_CST, 32'h0);
            chk(rd, {29'h0, v[5:3]});
            apb(1'b0, A_DST, 32'h0);
            chk(rd, {29'h0, v[2:0]});
        end
        apb(1'b1, A_STB, 32'h8d);
        repeat (3) @(posedge pclk);
        chk({28'h0, clk_taps_q}, 32'h5);
        apb(1'b1, A_CST, 32'h2);
        apb(1'b0, A_CST, 32'h0);
        chk(rd, 32'h5);
        apb(1'b1, A_STB, 32'hb0);
        repeat (3) @(posedge pclk);
        chk({28'h0, data_taps_q}, 32'h9);
        apb(1'b1, A_STB, 32'h0);
        $display("test_manual done");
    endtask

    task automatic test_search();
        set_far(3'h0, 3'h2, 4'h3, 1'b0);
        apb(1'b1, A_RANGE, 32'h89);
        apb(1'b1, A_EQLIM, 32'h23);
        apb(1'b1, A_CFG, 32'h70);
        wait_cand(4'h8, 4'h2, 50);
        wait_cand(4'h8, 4'h3, 4100);
        wait_cand(4'h9, 4'h2, 4100);
        wait_cand(4'h9, 4'h3, 4100);
        wait_done(4100);
        repeat (100) @(posedge pclk);
        wait_cand(4'h9, 4'h3, 0);
        apb(1'b0, A_DST, 32'h0);
        chk(rd, 32'h2);
        $display("test_search done");
    endtask

    // inner loop steps the position first, so (9,2) follows (8,2)
    task automatic test_inner();
        apb(1'b1, A_CFG, 32'h72);
        set_far(3'h0, 3'h2, 4'h2, 1'b0);
        apb(1'b1, A_CTRL, 32'h0c);
        wait_cand(4'h8, 4'h2, 50);
        wait_cand(4'h9, 4'h2, 4100);
        wait_done(4100);
        $display("test_inner done");
    endtask

    task automatic test_wrap();
        apb(1'b1, A_EQLIM, 32'h22);
        apb(1'b1, A_CTRL, 32'h0c);
        set_far(3'h0, 3'h1, 4'h2, 1'b1);
        wait_cand(4'h8, 4'h2, 50);
        wait_cand(4'h9, 4'h2, 4100);
        wait_cand(4'h8, 4'h2, 4100);
        chk({31'h0, search_done_q}, 32'h0);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd, 32'h4);
        // with parity checking off the corrupted setting is good enough
        apb(1'b1, A_CFG, 32'h60);
        wait_done(12100);
        chk({29'h0, data_delay_q}, 32'h1);
        $display("test_wrap done");
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        set_far(3'h7, 3'h7, 4'h0, 1'b0);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_manual();
        test_search();
        test_inner();
        test_wrap();
        tally_and_finish();
    end
endmodule
